// >>> rtl/mmc_memory_map_config.v
/*
 * memory map configuration registers and address decode: bank selects,
 * low-memory relocation, bios shadow and write protect, parity control,
 * boot rom chip select and the pointer-activity speed-up timer.
 * assumes: host i/o cycles arrive as one-cycle write/read strobes on the
 * core clock; memory address and strobe come from logic on the same clock;
 * pointer interrupt lines come from outside and are synchronised here.
 */
// Operation
// - two-bit density picks bank dram organisation
// - base registers hold bank starts A24-A17
// - bank size derived from density setting
// - interleaved group decodes as doubled/quadrupled region
// - bank enable bits; cleared bank never responds
// - drive strength field steers address drivers
// - split extent selects relocated low region
// - split destination bits give A24-A19
// - low memory disable field blanks dram
// - upper protect bit blocks writes above boundary
// - bios protect bit blocks shadow writes
// - parity invert bit inverts stored parity
// - parity kill overrides legacy parity control
// - shadow select picks shadowed bios ranges
// - top-of-space rom never shadowed
// - select 11 maps video shadow at 0c0000
// - video length field sizes video window
// - layout 00 rom select at e/fe ranges
// - layout 10 rom select at f/ff/video
// - pointer interrupt choice triggers one-second boost
// - boundary register holds A24-A17 limit
// - legacy bit disables parity checking
`timescale 1ns/1ps
`include "mmc_regs.vh"

module mmc_memory_map_config #(
  parameter BOOST_CYCLES = `MMC_BOOST_CYC
) (
  input  wire        core_clk_i,
  input  wire        rst_i,
  input  wire [15:0] io_addr_i,
  input  wire [15:0] io_wdata_i,
  input  wire        io_wr_i,
  input  wire        io_rd_i,
  output reg  [15:0] io_rdata_o,
  input  wire        legacy_parity_check_off_i,
  input  wire        auto_speedup_i,
  input  wire [2:0]  pointer_irq_i,
  input  wire [23:0] mem_addr_i,
  input  wire        mem_valid_i,
  input  wire        mem_write_i,
  output reg  [3:0]  bank_sel_o,
  output reg         dram_hit_o,
  output reg  [23:0] dram_addr_o,
  output reg         dram_write_block_o,
  output reg         boot_rom_select_o,
  output reg  [4:0]  chip_sel_code_o,
  output wire [1:0]  address_drive_strength_o,
  output wire        parity_invert_o,
  output wire        parity_check_on_o,
  output reg         speed_boost_o
);

  // configuration storage
  reg [15:0] bank01_base;
  reg [15:0] bank23_base;
  reg [15:0] split_bank_ctrl;
  reg [15:0] shadow_protect_ctrl;
  reg [7:0]  upper_mem_bound;
  reg [7:0]  bank_density_ctrl;

  // register writes
  // writes land at one edge, so the decode sees them from the next cycle
  // split bits 1:0 and shadow bits 7:6 are never stored, so they read back zero
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bank01_base         <= `MMC_RST_BASE;
      bank23_base         <= `MMC_RST_BASE;
      split_bank_ctrl     <= `MMC_RST_SPLIT;
      shadow_protect_ctrl <= `MMC_RST_SHADOW;
      upper_mem_bound     <= `MMC_RST_BOUND;
      bank_density_ctrl   <= `MMC_RST_DENSITY;
    end else if (io_wr_i) begin
      case (io_addr_i)
        `MMC_PORT_BANK01_BASE: bank01_base <= io_wdata_i;
        `MMC_PORT_BANK23_BASE: bank23_base <= io_wdata_i;
        `MMC_PORT_SPLIT_BANK:  split_bank_ctrl <= {io_wdata_i[15:2], 2'b00};
        `MMC_PORT_SHADOW_PROT: shadow_protect_ctrl <= io_wdata_i & `MMC_SHD_WMASK;
        `MMC_PORT_UPPER_BOUND: upper_mem_bound <= io_wdata_i[7:0];
        `MMC_PORT_DENSITY:     bank_density_ctrl <= io_wdata_i[7:0];
        default: ;
      endcase
    end
  end

  // the read answer stands until the next read strobe, not just one cycle
  // register readback, unmapped ports read zero
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_rdata_o <= 16'h0000;
    end else if (io_rd_i) begin
      case (io_addr_i)
        `MMC_PORT_BANK01_BASE: io_rdata_o <= bank01_base;
        `MMC_PORT_BANK23_BASE: io_rdata_o <= bank23_base;
        `MMC_PORT_SPLIT_BANK:  io_rdata_o <= split_bank_ctrl;
        `MMC_PORT_SHADOW_PROT: io_rdata_o <= shadow_protect_ctrl;
        `MMC_PORT_UPPER_BOUND: io_rdata_o <= {8'h00, upper_mem_bound};
        `MMC_PORT_DENSITY:     io_rdata_o <= {8'h00, bank_density_ctrl};
        default:               io_rdata_o <= 16'h0000;
      endcase
    end
  end

  // field views; the top bit of each A24-A17 field lies above the 24-bit bus
  wire [3:0] bank_on      = split_bank_ctrl[`MMC_SPL_EN_HI:`MMC_SPL_EN_LO];
  wire [1:0] reloc_extent = split_bank_ctrl[`MMC_SPL_EXT_HI:`MMC_SPL_EXT_LO];
  wire [5:0] reloc_dest   = split_bank_ctrl[`MMC_SPL_DST_HI:`MMC_SPL_DST_LO];
  wire [1:0] low_disable  = shadow_protect_ctrl[`MMC_SHD_DIS_HI:`MMC_SHD_DIS_LO];
  wire       upper_wp_on  = shadow_protect_ctrl[`MMC_SHD_UPWP];
  wire       bios_wp_on   = shadow_protect_ctrl[`MMC_SHD_BWP];
  wire [1:0] shadow_sel   = shadow_protect_ctrl[`MMC_SHD_SEL_HI:`MMC_SHD_SEL_LO];
  wire [1:0] video_len    = shadow_protect_ctrl[`MMC_SHD_VB_HI:`MMC_SHD_VB_LO];
  wire [1:0] rom_layout   = shadow_protect_ctrl[`MMC_SHD_ROM_HI:`MMC_SHD_ROM_LO];
  wire [1:0] ptr_ctrl     = shadow_protect_ctrl[`MMC_SHD_PTR_HI:`MMC_SHD_PTR_LO];
  wire [31:0] bank_bases  = {bank23_base, bank01_base};

  // drive strength straight from the register
  assign address_drive_strength_o = split_bank_ctrl[`MMC_SPL_DRV_HI:`MMC_SPL_DRV_LO];
  assign parity_invert_o = shadow_protect_ctrl[`MMC_SHD_PINV];
  // kill bit overrides legacy control
  // the legacy bit comes from logic on this clock, so it needs no synchroniser
  // legacy bit also disables checking
  assign parity_check_on_o = ~shadow_protect_ctrl[`MMC_SHD_PKILL] &
                             ~legacy_parity_check_off_i;

  // address regions in 64k units (A23-A16)
  wire [7:0] seg = mem_addr_i[23:16];
  wire       in_low_1m = (mem_addr_i[23:20] == 4'h0);

  // relocation window end by extent: 0d, 0e or 0f segment
  reg [7:0] reloc_top;
  always @* begin
    case (reloc_extent)
      2'b01:   reloc_top = 8'h0d;
      2'b10:   reloc_top = 8'h0e;
      2'b11:   reloc_top = 8'h0f;
      default: reloc_top = 8'h00;
    endcase
  end
  wire in_reloc_src = (reloc_extent != 2'b00) && in_low_1m &&
                      (seg >= 8'h0a) && (seg <= reloc_top);

  // A24 of the destination falls outside the 24-bit bus and is dropped
  // destination supplies A24-A19, offset kept from 0a0000
  wire [23:0] reloc_off  = mem_addr_i - 24'h0a0000;
  wire [23:0] eff_addr   = in_reloc_src ? {reloc_dest[4:0], 19'h00000} + reloc_off
                                        : mem_addr_i;

  // the window grows in 16k steps upward from 0c0000
  // video window length 16k..64k, A15-A14 at or below the limit
  wire in_video_win = (seg == 8'h0c) && (mem_addr_i[15:14] <= video_len);

  // shadowed bios ranges, video at 0c with select 11
  // top-of-space rom is outside the low 1m and never shadowed
  reg in_shadow;
  always @* begin
    case (shadow_sel)
      2'b01:   in_shadow = (seg == 8'h0f);
      2'b10:   in_shadow = (seg == 8'h0e) || (seg == 8'h0f);
      2'b11:   in_shadow = (seg == 8'h0f) || in_video_win;
      default: in_shadow = 1'b0;
    endcase
  end

  // low memory blanking from 512k/256k/128k up to 640k
  reg [7:0] blank_lo;
  always @* begin
    case (low_disable)
      2'b01:   blank_lo = 8'h08;
      2'b10:   blank_lo = 8'h04;
      2'b11:   blank_lo = 8'h02;
      default: blank_lo = 8'h0a;
    endcase
  end
  wire in_blank = in_low_1m && (seg >= blank_lo) && (seg < 8'h0a);

  // the hole between 640k and 1m answers only when shadowed
  // relocated segments are served through the relocated address instead
  wire in_hole = in_low_1m && (seg >= 8'h0a) && !in_reloc_src && !in_shadow;

  // per-bank decode
  wire [3:0] bank_match;
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_bank
      wire [1:0] dens = bank_density_ctrl[2*b+1:2*b];
      wire [7:0] start = bank_bases[8*b+7:8*b];
      // a bank pairs with its partner (0/1, 2/3) when both are on with one start
      // interleave widens the region by one or two address bits
      wire [1:0] ilv = (bank_on[b] && bank_on[b^1] && bank_bases[8*(b^1)+7:8*(b^1)] == start)
                       ? ((bank_on == 4'hf && bank_bases[7:0] == bank_bases[15:8] &&
                           bank_bases[15:8] == bank_bases[23:16] &&
                           bank_bases[23:16] == bank_bases[31:24]) ? 2'd2 : 2'd1)
                       : 2'd0;
      // size in 128k units: 1, 4, 16, 64
      wire [4:0] lg = {2'b00, dens, 1'b0} + {3'b000, ilv};
      wire [8:0] span = 9'h001 << lg;
      wire [8:0] a17  = {1'b0, eff_addr[23:17]};
      wire [8:0] s17  = {1'b0, start};
      assign bank_match[b] = bank_on[b] && (a17 >= s17) && (a17 < s17 + span);
    end
  endgenerate

  // lowest-numbered matching bank wins on overlap
  // overlaps come from interleaved partners and from bad programming; fixed priority keeps one select
  reg [3:0] bank_pick;
  always @* begin
    casez (bank_match)
      4'b???1: bank_pick = 4'b0001;
      4'b??10: bank_pick = 4'b0010;
      4'b?100: bank_pick = 4'b0100;
      4'b1000: bank_pick = 4'b1000;
      default: bank_pick = 4'b0000;
    endcase
  end

  // boundary holds A24-A17; region above is upper memory
  // the address has no A24, so a zero stands in for it at the top
  wire above_bound = ({1'b0, mem_addr_i[23:17]} > upper_mem_bound);

  // layout 00 rom ranges, layout 10 rom ranges
  reg rom_hit;
  always @* begin
    case (rom_layout)
      2'b00:   rom_hit = (seg == 8'h0e) || (seg == 8'h0f) ||
                         (seg == 8'hfe) || (seg == 8'hff);
      2'b10:   rom_hit = (seg == 8'h0f) || (seg == 8'hff) || in_video_win;
      default: rom_hit = (seg == 8'h0f) || (seg == 8'hff);
    endcase
  end

  // registered memory decode outputs
  // selects drop in idle cycles so a stale select never lingers
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bank_sel_o         <= 4'h0;
      dram_hit_o         <= 1'b0;
      dram_addr_o        <= 24'h000000;
      dram_write_block_o <= 1'b0;
      boot_rom_select_o  <= 1'b0;
      chip_sel_code_o    <= `MMC_CS_IDLE;
    end else if (mem_valid_i) begin
      // blanked low range and unshadowed hole give no bank
      if (in_blank || in_hole) begin
        bank_sel_o <= 4'h0;
        dram_hit_o <= 1'b0;
      end else begin
        bank_sel_o <= bank_pick;
        dram_hit_o <= |bank_match;
      end
      dram_addr_o <= eff_addr;
      dram_write_block_o <= mem_write_i &&
                            ((upper_wp_on && above_bound) || (bios_wp_on && in_shadow));
      // shadowed reads come from dram, so the rom stays quiet there
      boot_rom_select_o <= rom_hit && !(in_shadow && !mem_write_i);
      // rom select drives chip-select code 00
      chip_sel_code_o <= (rom_hit && !(in_shadow && !mem_write_i)) ? `MMC_ROM_CS_CODE
                                                                     : `MMC_CS_IDLE;
    end else begin
      bank_sel_o         <= 4'h0;
      dram_hit_o         <= 1'b0;
      dram_write_block_o <= 1'b0;
      boot_rom_select_o  <= 1'b0;
      chip_sel_code_o    <= `MMC_CS_IDLE;
    end
  end

  // pointer interrupt synchroniser: three stages, change counts when 2 and 3 agree
  // only the second stage reads the first, so metastability stays contained
  reg [2:0] irq_s1;
  reg [2:0] irq_s2;
  reg [2:0] irq_s3;
  reg [2:0] irq_q;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_s1 <= 3'h0;
      irq_s2 <= 3'h0;
      irq_s3 <= 3'h0;
      irq_q  <= 3'h0;
    end else begin
      irq_s1 <= pointer_irq_i;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      irq_q  <= (irq_s2 & irq_s3) | (irq_q & (irq_s2 | irq_s3));
    end
  end

  // limitation: selecting a line that is already high counts as one edge
  // pick the selected pointer interrupt: 01 int12, 10 int4, 11 int3
  reg ptr_level;
  always @* begin
    case (ptr_ctrl)
      2'b01:   ptr_level = irq_q[0];
      2'b10:   ptr_level = irq_q[1];
      2'b11:   ptr_level = irq_q[2];
      default: ptr_level = 1'b0;
    endcase
  end

  reg        ptr_prev;
  reg [31:0] boost_cnt;
  wire       ptr_rise = ptr_level & ~ptr_prev;

  // the count runs on the core clock, so BOOST_CYCLES must match its rate
  // speed_boost_o stands for exactly BOOST_CYCLES cycles after the edge
  // one-second boost, retriggered by each new activity edge
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_prev      <= 1'b0;
      boost_cnt     <= 32'h00000000;
      speed_boost_o <= 1'b0;
    end else begin
      ptr_prev <= ptr_level;
      if (ptr_rise && auto_speedup_i) begin
        boost_cnt     <= BOOST_CYCLES[31:0] - 32'h00000001;
        speed_boost_o <= 1'b1;
      end else if (boost_cnt != 32'h00000000) begin
        boost_cnt <= boost_cnt - 32'h00000001;
      end else begin
        speed_boost_o <= 1'b0;
      end
    end
  end

endmodule

// >>> rtl/mmc_regs.vh
/*
 * register offsets, field positions, reset values and timing counts for
 * the memory map configuration block.
 * assumes: included by the design file; offsets are host i/o port numbers.
 */
`ifndef MMC_REGS_VH
`define MMC_REGS_VH

// i/o port numbers of the writable registers
`define MMC_PORT_BANK01_BASE  16'h4872
`define MMC_PORT_BANK23_BASE  16'h5072
`define MMC_PORT_SPLIT_BANK   16'h5872
`define MMC_PORT_SHADOW_PROT  16'h6072
`define MMC_PORT_UPPER_BOUND  16'hc072
`define MMC_PORT_DENSITY      16'h3872

// reset values
`define MMC_RST_BASE          16'h0000
`define MMC_RST_SPLIT         16'h0000
`define MMC_RST_SHADOW        16'h0004
`define MMC_RST_BOUND         8'h00
`define MMC_RST_DENSITY       8'h00

// split_bank_ctrl fields
`define MMC_SPL_EN_HI         15
`define MMC_SPL_EN_LO         12
`define MMC_SPL_DRV_HI        11
`define MMC_SPL_DRV_LO        10
`define MMC_SPL_EXT_HI        9
`define MMC_SPL_EXT_LO        8
`define MMC_SPL_DST_HI        7
`define MMC_SPL_DST_LO        2

// shadow_protect_ctrl fields
`define MMC_SHD_DIS_HI        15
`define MMC_SHD_DIS_LO        14
`define MMC_SHD_UPWP          13
`define MMC_SHD_BWP           12
`define MMC_SHD_PINV          11
`define MMC_SHD_PKILL         10
`define MMC_SHD_SEL_HI        9
`define MMC_SHD_SEL_LO        8
`define MMC_SHD_VB_HI         5
`define MMC_SHD_VB_LO         4
`define MMC_SHD_ROM_HI        3
`define MMC_SHD_ROM_LO        2
`define MMC_SHD_PTR_HI        1
`define MMC_SHD_PTR_LO        0
`define MMC_SHD_WMASK         16'hff3f

// chip-select code that names the boot rom
`define MMC_ROM_CS_CODE       5'h00
// chip-select code driven when no decoded device is selected
`define MMC_CS_IDLE           5'h1f

// speed-up hold time in ms and the derived cycle count at 100 mhz
`define MMC_BOOST_MS          1000
`define MMC_CLK_MHZ           100
`define MMC_BOOST_CYC         (`MMC_BOOST_MS * 1000 * `MMC_CLK_MHZ)

`endif

// >>> test/mmc_memory_map_config_sva.sv
/* port checker for the memory map configuration block.
   assumes: bound to the design top; only its ports are seen. */
`timescale 1ns/1ps
module mmc_memory_map_config_sva (
  input wire        core_clk_i,
  input wire        rst_i,
  input wire [15:0] io_addr_i,
  input wire        io_rd_i,
  input wire [15:0] io_rdata_o,
  input wire        legacy_parity_check_off_i,
  input wire        auto_speedup_i,
  input wire        mem_valid_i,
  input wire        mem_write_i,
  input wire [3:0]  bank_sel_o,
  input wire        dram_hit_o,
  input wire        dram_write_block_o,
  input wire        boot_rom_select_o,
  input wire [4:0]  chip_sel_code_o,
  input wire        parity_check_on_o,
  input wire        speed_boost_o
);
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ports that answer a read; anything else must read as zero
  wire mapped = io_addr_i == 16'h4872 || io_addr_i == 16'h5072 || io_addr_i == 16'h5872 ||
                io_addr_i == 16'h6072 || io_addr_i == 16'hc072 || io_addr_i == 16'h3872;
  sequence s_read(p);
    io_rd_i && io_addr_i == p;
  endsequence
  sequence s_boost_start;
    $rose(speed_boost_o);
  endsequence
  a_unmapped_read_zero: assert property (
    io_rd_i && !mapped |=> io_rdata_o == 16'h0000) else $error("unmapped read not zero");
  a_split_low_ignored: assert property (
    s_read(16'h5872) |=> io_rdata_o[1:0] == 2'b00) else $error("split bits 1:0 not zero");
  a_shadow_rsvd_zero: assert property (
    s_read(16'h6072) |=> io_rdata_o[7:6] == 2'b00) else $error("shadow bits 7:6 not zero");
  a_idle_no_hit: assert property (
    !mem_valid_i |=> !dram_hit_o && bank_sel_o == 4'h0) else $error("hit without cycle");
  a_hit_one_bank: assert property (
    dram_hit_o |-> $onehot(bank_sel_o)) else $error("hit without single bank");
  a_rom_code_match: assert property (
    chip_sel_code_o == (boot_rom_select_o ? 5'h00 : 5'h1f)) else $error("rom code wrong");
  a_legacy_kill: assert property (
    legacy_parity_check_off_i |-> !parity_check_on_o) else $error("parity check left on");
  a_block_needs_write: assert property (
    dram_write_block_o |-> $past(mem_valid_i && mem_write_i)) else $error("block on no write");
  a_boost_holds: assert property (
    s_boost_start |-> speed_boost_o [*8]) else $error("boost dropped early");
  a_boost_gated: assert property (
    s_boost_start |-> $past(auto_speedup_i)) else $error("boost without auto speed-up");
endmodule

bind mmc_memory_map_config mmc_memory_map_config_sva u_mmc_memory_map_config_sva (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
  .io_rdata_o(io_rdata_o), .legacy_parity_check_off_i(legacy_parity_check_off_i),
  .auto_speedup_i(auto_speedup_i), .mem_valid_i(mem_valid_i), .mem_write_i(mem_write_i),
  .bank_sel_o(bank_sel_o), .dram_hit_o(dram_hit_o), .dram_write_block_o(dram_write_block_o),
  .boot_rom_select_o(boot_rom_select_o), .chip_sel_code_o(chip_sel_code_o),
  .parity_check_on_o(parity_check_on_o), .speed_boost_o(speed_boost_o));

// >>> test/mmc_pointer_model.sv
/* pointer device model: raises and drops one interrupt line.
   assumes: called by the bench; lines are plain levels, idle low. */
`timescale 1ns/1ps
module mmc_pointer_model (
  input  wire       core_clk_i,
  output reg  [2:0] irq_o
);
  // lines idle low until a pointer event
  initial begin
    irq_o = 3'h0;
  end
  // raise off the falling edge so the synchroniser sees a clean level
  task raise(input integer k);
    begin
      @(negedge core_clk_i);
      irq_o[k] = 1'b1;
    end
  endtask
  task drop(input integer k);
    irq_o[k] = 1'b0;
  endtask
endmodule

// >>> test/test_memory_map_config.sv
/* bench for the memory map configuration block: registers, bank decode,
   relocation, shadow, rom select, parity and pointer speed-up.
   assumes: design, checker and pointer model compiled alongside. */
`timescale 1ns/1ps
module test_memory_map_config;
  reg         core_clk_i;
  reg         rst_i;
  reg  [15:0] io_addr_i;
  reg  [15:0] io_wdata_i;
  reg         io_wr_i;
  reg         io_rd_i;
  reg         leg_off;
  reg         auto_on;
  reg  [23:0] mem_addr_i;
  reg         mem_valid_i;
  reg         mem_write_i;
  wire [15:0] io_rdata_o;
  wire [2:0]  irq;
  wire [3:0]  bank_sel_o;
  wire        hit;
  wire [23:0] daddr;
  wire        wblk;
  wire        rom;
  wire [4:0]  cs_code;
  wire [1:0]  drive;
  wire        pinv;
  wire        pchk;
  wire        boost;
  integer     bad_count;
  integer     n_tests;
  integer     i;
  integer     n;

  // boost shortened to 20 cycles so a run stays short
  mmc_memory_map_config #(.BOOST_CYCLES(20)) u_mmc_memory_map_config (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o),
    .legacy_parity_check_off_i(leg_off), .auto_speedup_i(auto_on), .pointer_irq_i(irq),
    .mem_addr_i(mem_addr_i), .mem_valid_i(mem_valid_i), .mem_write_i(mem_write_i),
    .bank_sel_o(bank_sel_o), .dram_hit_o(hit), .dram_addr_o(daddr),
    .dram_write_block_o(wblk), .boot_rom_select_o(rom), .chip_sel_code_o(cs_code),
    .address_drive_strength_o(drive), .parity_invert_o(pinv), .parity_check_on_o(pchk),
    .speed_boost_o(boost));
  mmc_pointer_model u_mmc_pointer_model (.core_clk_i(core_clk_i), .irq_o(irq));

  // 100 mhz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task chk(input string nm, input [23:0] e, input [23:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // host i/o cycles: one-cycle strobes raised at the falling edge
  task wr(input [15:0] a, input [15:0] d);
    begin
      @(negedge core_clk_i);
      io_addr_i = a;
      io_wdata_i = d;
      io_wr_i = 1'b1;
      @(negedge core_clk_i);
      io_wr_i = 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [15:0] e);
    begin
      @(negedge core_clk_i);
      io_addr_i = a;
      io_rd_i = 1'b1;
      @(negedge core_clk_i);
      io_rd_i = 1'b0;
      chk("io_rdata", e, io_rdata_o);
    end
  endtask
  task cfg(input [15:0] dn, input [15:0] b01, input [15:0] sp, input [15:0] sh);
    begin
      wr(16'h3872, dn);
      wr(16'h4872, b01);
      wr(16'h5872, sp);
      wr(16'h6072, sh);
    end
  endtask
  // one memory cycle; outputs are judged the cycle after it is taken
  task mc(input [23:0] a, input w, input eh, input er);
    begin
      @(negedge core_clk_i);
      mem_addr_i = a;
      mem_write_i = w;
      mem_valid_i = 1'b1;
      @(negedge core_clk_i);
      mem_valid_i = 1'b0;
      chk("hit", eh, hit);
      chk("rom", er, rom);
    end
  endtask

  task t_regs;
    begin
      rd(16'h5872, 16'h0000);
      rd(16'h6072, 16'h0004);
      wr(16'h4872, 16'h2a15);
      wr(16'h1234, 16'hffff);
      rd(16'h4872, 16'h2a15);
      rd(16'h1234, 16'h0000);
      for (i = 0; i < 4; i = i + 1) begin
        wr(16'h5872, 16'h0003 | (i << 10));
        chk("drive", i, drive);
      end
      rd(16'h5872, 16'h0c00);
      wr(16'h6072, 16'hffff);
      rd(16'h6072, 16'hff3f);
      chk("pinv", 1, pinv);
      chk("pchk", 0, pchk);
      wr(16'h6072, 16'h0000);
      chk("pchk", 1, pchk);
      leg_off = 1'b1;
      #1 chk("pchk", 0, pchk);
      @(negedge core_clk_i);
      leg_off = 1'b0;
    end
  endtask
  // software keeps starts aligned and interleave members paired
  task t_bank;
    begin
      cfg(16'h0000, 16'h0000, 16'h1000, 16'h0000);
      mc(24'h01fffe, 1'b0, 1'b1, 1'b0);
      chk("bank_sel", 4'h1, bank_sel_o);
      mc(24'h020000, 1'b0, 1'b0, 1'b0);
      wr(16'h3872, 16'h0001);
      mc(24'h020000, 1'b0, 1'b1, 1'b0);
      wr(16'h3872, 16'h0003);
      mc(24'h7ffffe, 1'b0, 1'b1, 1'b0);
      wr(16'h5872, 16'h0000);
      mc(24'h000000, 1'b0, 1'b0, 1'b0);
      cfg(16'h0005, 16'h0000, 16'h3000, 16'h0000);
      mc(24'h090000, 1'b0, 1'b1, 1'b0);
      for (i = 1; i < 4; i = i + 1) begin
        wr(16'h6072, i << 14);
        mc(24'h100000 >> i, 1'b0, 1'b0, 1'b0);
        mc((24'h100000 >> i) - 1, 1'b0, 1'b1, 1'b0);
      end
      wr(16'hc072, 16'h0008);
      cfg(16'h0002, 16'h0000, 16'h1000, 16'h2000);
      mc(24'h180000, 1'b1, 1'b1, 1'b0);
      chk("wblk", 1, wblk);
      mc(24'h040000, 1'b1, 1'b1, 1'b0);
      chk("wblk", 0, wblk);
    end
  endtask
  // one 2 mb bank split to 100000, a 512k-aligned spot
  task t_split;
    begin
      cfg(16'h0002, 16'h0000, 16'h1008, 16'h0000);
      mc(24'h0a0010, 1'b0, 1'b0, 1'b0);
      for (i = 1; i < 4; i = i + 1) begin
        wr(16'h5872, 16'h1008 | (i << 8));
        mc(24'h0d0000, 1'b0, 1'b1, 1'b0);
        chk("daddr", 24'h130000, daddr);
        if (i < 3)
          mc(24'h0e0000 + (i - 1) * 24'h010000, 1'b0, 1'b0, 1'b1);
      end
    end
  endtask
  task t_rom;
    begin
      cfg(16'h0002, 16'h0000, 16'h1000, 16'h0000);
      mc(24'hfe0000, 1'b0, 1'b0, 1'b1);
      chk("cs_code", 5'h00, cs_code);
      mc(24'h0f0000, 1'b0, 1'b0, 1'b1);
      wr(16'h6072, 16'h0100);
      mc(24'h0f0000, 1'b0, 1'b1, 1'b0);
      wr(16'h6072, 16'h0200);
      mc(24'h0e0000, 1'b0, 1'b1, 1'b0);
      wr(16'h6072, 16'h0300);
      mc(24'h0c0000, 1'b0, 1'b1, 1'b0);
      mc(24'hfe0000, 1'b0, 1'b0, 1'b1);
      wr(16'h6072, 16'h1100);
      mc(24'h0f0000, 1'b1, 1'b1, 1'b1);
      chk("wblk", 1, wblk);
      for (i = 0; i < 4; i = i + 1) begin
        wr(16'h6072, 16'h0008 | (i << 4));
        mc(24'h0c0000 + (i + 1) * 24'h004000 - 1, 1'b0, 1'b0, 1'b1);
        mc(24'h0c0000 + (i + 1) * 24'h004000, 1'b0, 1'b0, 1'b0);
      end
      mc(24'h0e0000, 1'b0, 1'b0, 1'b0);
      mc(24'hff0000, 1'b0, 1'b0, 1'b1);
    end
  endtask
  task t_boost;
    begin
      auto_on = 1'b1;
      wr(16'h6072, 16'h0001);
      u_mmc_pointer_model.raise(1);
      repeat (8) @(negedge core_clk_i);
      chk("boost", 0, boost);
      u_mmc_pointer_model.drop(1);
      for (i = 1; i < 4; i = i + 1) begin
        wr(16'h6072, i);
        u_mmc_pointer_model.raise(i - 1);
        for (n = 0; n < 10 && boost !== 1'b1; n = n + 1) @(negedge core_clk_i);
        for (n = 0; n < 100 && boost === 1'b1; n = n + 1) @(negedge core_clk_i);
        chk("boost_len", 20, n);
        u_mmc_pointer_model.drop(i - 1);
      end
      auto_on = 1'b0;
      // let the line settle low so the raise below is a real edge
      repeat (4) @(negedge core_clk_i);
      u_mmc_pointer_model.raise(2);
      repeat (8) @(negedge core_clk_i);
      chk("boost", 0, boost);
    end
  endtask

  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // whole run needs a few hundred cycles; cut a hang well beyond that
  initial begin
    #200000;
    bad_count = bad_count + 1;
    finish_test;
  end
  // reset for six cycles, then the scenarios in turn
  initial begin
    bad_count = 0;
    n_tests = 0;
    rst_i = 1'b1;
    io_addr_i = 16'h0000;
    io_wdata_i = 16'h0000;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    leg_off = 1'b0;
    auto_on = 1'b0;
    mem_addr_i = 24'h000000;
    mem_valid_i = 1'b0;
    mem_write_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_regs;
    t_bank;
    t_split;
    t_rom;
    t_boost;
    finish_test;
  end
endmodule
